// [logic/can_irq_pkg.sv]
// Purpose: constants and carriers for the message object / interrupt block
// Assumes: APB word registers, byte address is four times the index
// Notes:   status interrupt code outranks every object code

package can_irq_pkg;
  localparam int NOBJ = 32;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [7:0] IDX_ID_LO  = 8'h08;
  localparam logic [7:0] IDX_ID_HI  = 8'h09;
  localparam logic [7:0] IDX_DATA0  = 8'h10;
  localparam logic [7:0] IDX_CTRL   = 8'h18;
  localparam logic [7:0] IDX_CFG    = 8'h19;
  localparam logic [7:0] IDX_CMD    = 8'h1A;
  localparam logic [7:0] IDX_STAT   = 8'h1B;
  localparam logic [7:0] IDX_CANCTL = 8'h1C;
  localparam logic [7:0] IDX_FUNC   = 8'h1D;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CMD_WR      = 7;
  localparam int CMD_CLRPEND = 6;
  localparam int CANCTL_IE   = 1;
  localparam int FUNC_POL    = 0;
  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [15:0] IRQ_NONE = 16'h0000;
  localparam logic [15:0] IRQ_STAT = 16'h8000;
  localparam logic        POL_RST  = 1'b1;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // bit 7 down to bit 0 of the object control byte
  typedef struct packed {
    logic fresh;
    logic overrun;
    logic pend;
    logic filt;
    logic tx_ie;
    logic rx_ie;
    logic remote;
    logic send_req;
  } obj_flags_s;

  // bit 7 valid, bit 5 direction (1 transmit), bits 3:0 length code
  typedef struct packed {
    logic       valid;
    logic       unused6;
    logic       dir;
    logic       unused4;
    logic [3:0] dlc;
  } obj_cfg_s;

  typedef struct packed {
    logic        rx_valid;
    logic        rx_remote;
    logic        rx_hit_exact;
    logic        rx_hit_masked;
    logic [5:0]  rx_obj;
    logic [3:0]  rx_dlc;
    logic [63:0] rx_data;
    logic        tx_done;
    logic [5:0]  tx_obj;
    logic        stat_valid;
    logic [4:0]  stat_val;
  } core_ev_s;
endpackage

// [logic/can_obj_ram.sv]
// Purpose: data bytes of all message objects
// Assumes: port b (core) wins over port a on the same word
// Notes:   read data registered, one cycle after the address

`timescale 1ns/1ps
`default_nettype none

module can_obj_ram (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        a_we,
  input  wire logic [4:0]  a_addr,
  input  wire logic [63:0] a_data,
  input  wire logic        b_we,
  input  wire logic [4:0]  b_addr,
  input  wire logic [63:0] b_data,
  input  wire logic [4:0]  rd_addr,
  output logic      [63:0] rd_data
);
  import can_irq_pkg::*;

  logic [63:0] mem [NOBJ];

  always_ff @(posedge pclk) begin
    if (a_we) begin
      mem[a_addr] <= a_data;
    end
    if (b_we) begin
      mem[b_addr] <= b_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 64'h0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

`default_nettype wire

// [logic/can_msg_irq.sv]
// Purpose: message object flags, data buffer and interrupt identifier
// Assumes: core events arrive on pclk; software on APB
// Notes:   byte k of a data word sits at bits 8k+7..8k
//
// Operation
// - object fresh flag set by a store, held until software clears it
// - store into receive object while fresh sets overrun flag
// - pending object is a source, chosen only if nothing higher pending
// - filter-use bit selects masked or exact acceptance match
// - transmit enable sets pending after successful transmission
// - receive enable sets pending after successful reception
// - remote enable lets matching remote frame set send request
// - send request reads one until transmission completes
// - byte zero first on the wire, each byte msb first
// - a stored data frame writes all eight bytes
// - handler status writable by software; a core update in the same cycle wins
// - identifier: 0 none, object number, or 8000h status
// - status ranks highest, then lower object numbers
// - line active while identifier nonzero and interrupt enable set
// - line polarity follows a configuration bit
// - pending until cleared; status cleared by reading status
// - core status update raises the status code only while interrupt enable set
// - software status writes neither raise nor clear interrupts
// - identifier updates even with the interrupt enable clear
// - after clearing, identifier moves to next pending or zero
// - read command may clear pending in the same transfer
// - identifier is 16 bits, low and high bytes
// - received length code stored; above 8 means eight bytes
// - receive object stores data frames; transmit object takes remotes
//
// Design decision made here: the APB register port.

`timescale 1ns/1ps
`default_nettype none

module can_msg_irq (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire can_irq_pkg::core_ev_s  core_ev,
  output logic      [31:0]            obj_send_request,
  output logic                        controller_irq_line
);
  import can_irq_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic obj_ok(input logic [5:0] o);
    return (o != 6'h00) && (o <= 6'd32);
  endfunction

  function automatic logic is_mapped(input logic [7:0] i);
    return (i == IDX_ID_LO) || (i == IDX_ID_HI) || (i[7:3] == IDX_DATA0[7:3])
        || ((i >= IDX_CTRL) && (i <= IDX_FUNC));
  endfunction

  // lower object number wins, status above all
  function automatic logic [15:0] irq_code(input logic stat, input logic [NOBJ-1:0] p);
    logic [15:0] c;
    c = IRQ_NONE;
    for (int k = NOBJ - 1; k >= 0; k--) begin
      if (p[k]) begin
        c = 16'(k + 1);
      end
    end
    if (stat) begin
      c = IRQ_STAT;
    end
    return c;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  obj_flags_s  flags_q [NOBJ];
  obj_flags_s  flags_d [NOBJ];
  obj_cfg_s    cfg_q [NOBJ];
  obj_cfg_s    cfg_d [NOBJ];
  obj_flags_s  buf_ctrl_q;
  obj_cfg_s    buf_cfg_q;
  logic [63:0] buf_data_q;
  logic [63:0] mem_rd;
  logic        load_q;
  logic [4:0]  stat_q;
  logic        stat_irq_q;
  logic        stat_irq_d;
  logic        ie_q;
  logic        pol_q;
  logic [15:0] id_q;
  logic [NOBJ-1:0] pend_vec;

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  wire       acc     = psel & penable;
  wire       take    = acc & pready;
  wire       rd_take = take & ~pwrite;
  wire       wr_take = take & pwrite;
  wire [7:0] idx     = paddr[9:2];
  wire       adr_ok  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && is_mapped(idx);

  wire       cmd_go    = wr_take && (idx == IDX_CMD) && obj_ok(pwdata[5:0]);
  wire       cmd_wr_go = cmd_go & pwdata[CMD_WR];
  wire       cmd_rd_go = cmd_go & ~pwdata[CMD_WR];
  wire       clr_pend  = cmd_rd_go & pwdata[CMD_CLRPEND];
  wire [4:0] cmd_i     = 5'(pwdata[5:0] - 6'd1);

  // ----------------------------------------
  // core side decode
  // ----------------------------------------
  wire [4:0] rx_i  = 5'(core_ev.rx_obj - 6'd1);
  wire [4:0] tx_i  = 5'(core_ev.tx_obj - 6'd1);
  wire       rx_in = core_ev.rx_valid && obj_ok(core_ev.rx_obj) && cfg_q[rx_i].valid;
  // filter-use bit picks which match the core reports
  wire       rx_acc = flags_q[rx_i].filt ? core_ev.rx_hit_masked : core_ev.rx_hit_exact;
  // data frames land only in receive objects
  wire       rx_store = rx_in && rx_acc && !core_ev.rx_remote && !cfg_q[rx_i].dir;
  wire       rmt_set  = rx_in && rx_acc && core_ev.rx_remote && cfg_q[rx_i].dir
                        && flags_q[rx_i].remote;
  wire       tx_fin   = core_ev.tx_done && obj_ok(core_ev.tx_obj);

  // ----------------------------------------
  // per-object flag update
  // ----------------------------------------
  // software write first, then core events, so a hardware set wins
  function automatic obj_flags_s next_flags(input obj_flags_s q, input obj_flags_s w,
                                            input logic cw, input logic cl, input logic rs,
                                            input logic rm, input logic tf);
    obj_flags_s d;
    d = q;
    if (cw) begin
      d = w;
    end
    if (cl) begin
      d.pend = 1'b0;
    end
    if (rs) begin
      d.overrun = d.overrun | q.fresh;
      d.fresh   = 1'b1;
      d.pend    = d.pend | d.rx_ie;
    end
    if (rm) begin
      d.send_req = 1'b1;
    end
    if (tf) begin
      d.send_req = 1'b0;
      d.pend     = d.pend | d.tx_ie;
    end
    return d;
  endfunction

  for (genvar g = 0; g < NOBJ; g++) begin : g_obj
    wire cw = cmd_wr_go && (cmd_i == 5'(g));
    wire rs = rx_store && (rx_i == 5'(g));
    assign flags_d[g] = next_flags(flags_q[g], buf_ctrl_q, cw,
                                   clr_pend && (cmd_i == 5'(g)), rs,
                                   rmt_set && (rx_i == 5'(g)),
                                   tx_fin && (tx_i == 5'(g)));
    // received length code kept as is; codes above 8 still mean 8 bytes
    assign cfg_d[g] = rs ? obj_cfg_s'{valid: cfg_q[g].valid, unused6: 1'b0, dir: cfg_q[g].dir,
                                      unused4: 1'b0, dlc: core_ev.rx_dlc}
                         : (cw ? buf_cfg_q : cfg_q[g]);
    assign pend_vec[g]         = flags_q[g].pend;
    assign obj_send_request[g] = flags_q[g].send_req;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flags_q[g] <= '0;
        cfg_q[g]   <= '0;
      end else begin
        flags_q[g] <= flags_d[g];
        cfg_q[g]   <= cfg_d[g];
      end
    end
  end

  // ----------------------------------------
  // data storage
  // ----------------------------------------
  // all eight bytes written whatever the length code
  can_obj_ram u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .a_we    (cmd_wr_go),
    .a_addr  (cmd_i),
    .a_data  (buf_data_q),
    .b_we    (rx_store),
    .b_addr  (rx_i),
    .b_data  (core_ev.rx_data),
    .rd_addr (cmd_i),
    .rd_data (mem_rd)
  );

  // ----------------------------------------
  // interface buffer
  // ----------------------------------------
  wire       wr_data = wr_take && (idx[7:3] == IDX_DATA0[7:3]);
  wire [5:0] wr_pos  = {idx[2:0], 3'b000};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_data_q <= 64'h0;
      buf_ctrl_q <= '0;
      buf_cfg_q  <= '0;
      load_q     <= 1'b0;
    end else begin
      load_q <= cmd_rd_go;
      if (load_q) begin
        buf_data_q <= mem_rd;
      end else if (wr_data) begin
        buf_data_q[wr_pos +: 8] <= pwdata[7:0];
      end
      // snapshot before the pending clear of the same command
      if (cmd_rd_go) begin
        buf_ctrl_q <= flags_q[cmd_i];
        buf_cfg_q  <= cfg_q[cmd_i];
      end else if (wr_take && (idx == IDX_CTRL)) begin
        buf_ctrl_q <= pwdata[7:0];
      end else if (wr_take && (idx == IDX_CFG)) begin
        buf_cfg_q <= pwdata[7:0] & 8'hAF;
      end
    end
  end

  // ----------------------------------------
  // status and controller config
  // ----------------------------------------
  // core update raises status code only when enabled; cpu writes never
  wire stat_set = core_ev.stat_valid & ie_q;
  wire stat_clr = rd_take && (idx == IDX_STAT);
  assign stat_irq_d = stat_set | (stat_irq_q & ~stat_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q     <= 5'h00;
      stat_irq_q <= 1'b0;
      ie_q       <= 1'b0;
      pol_q      <= POL_RST;
    end else begin
      stat_irq_q <= stat_irq_d;
      if (core_ev.stat_valid) begin
        stat_q <= core_ev.stat_val;
      end else if (wr_take && (idx == IDX_STAT)) begin
        stat_q <= pwdata[4:0];
      end
      if (wr_take && (idx == IDX_CANCTL)) begin
        ie_q <= pwdata[CANCTL_IE];
      end
      if (wr_take && (idx == IDX_FUNC)) begin
        pol_q <= pwdata[FUNC_POL];
      end
    end
  end

  // ----------------------------------------
  // identifier and interrupt line
  // ----------------------------------------
  // identifier runs regardless of the enable; only the line is gated
  wire [15:0] id_d   = irq_code(stat_irq_q, pend_vec);
  wire        active = (id_q != IRQ_NONE) & ie_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_q                <= IRQ_NONE;
      controller_irq_line <= 1'b0;
    end else begin
      id_q                <= id_d;
      controller_irq_line <= ~(active ^ pol_q);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // identifier bytes come from one register and reading them changes nothing
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (idx[7:3] == IDX_DATA0[7:3]) begin
      rd_byte = buf_data_q[wr_pos +: 8];
    end else begin
      case (idx)
        IDX_ID_LO:  rd_byte = id_q[7:0];
        IDX_ID_HI:  rd_byte = id_q[15:8];
        IDX_CTRL:   rd_byte = buf_ctrl_q;
        IDX_CFG:    rd_byte = buf_cfg_q;
        IDX_STAT:   rd_byte = {3'b000, stat_q};
        IDX_CANCTL: rd_byte = {6'h00, ie_q, 1'b0};
        IDX_FUNC:   rd_byte = {7'h00, pol_q};
        default:    rd_byte = 8'h00;
      endcase
    end
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~adr_ok;
      if (acc & ~pready) begin
        prdata <= adr_ok ? {24'h0, rd_byte} : 32'h0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_fresh_store;
    rx_store && flags_q[rx_i].fresh;
  endsequence

  property p_overrun;
    @(posedge pclk) disable iff (!presetn)
    s_fresh_store |=> flags_q[$past(rx_i)].overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not set");

  property p_fresh;
    @(posedge pclk) disable iff (!presetn)
    rx_store |=> flags_q[$past(rx_i)].fresh;
  endproperty
  a_fresh: assert property (p_fresh) else $error("fresh flag not set");

  property p_rx_pend;
    @(posedge pclk) disable iff (!presetn)
    rx_store && flags_q[rx_i].rx_ie && !cmd_wr_go |=> flags_q[$past(rx_i)].pend;
  endproperty
  a_rx_pend: assert property (p_rx_pend) else $error("rx pending missed");

  property p_tx_pend;
    @(posedge pclk) disable iff (!presetn)
    tx_fin && !cmd_wr_go |=> !flags_q[$past(tx_i)].send_req
      && (flags_q[$past(tx_i)].pend == ($past(flags_q[tx_i].pend) || $past(flags_q[tx_i].tx_ie)
      || $past(rx_store && rx_i == tx_i && flags_q[tx_i].rx_ie)));
  endproperty
  a_tx_pend: assert property (p_tx_pend) else $error("tx completion wrong");

  property p_remote;
    @(posedge pclk) disable iff (!presetn)
    rx_in && core_ev.rx_remote && !cfg_q[rx_i].dir
      |=> flags_q[$past(rx_i)].send_req == $past(flags_q[rx_i].send_req)
      || $past(cmd_wr_go || tx_fin);
  endproperty
  a_remote: assert property (p_remote) else $error("remote touched rx object");

  property p_stat_top;
    @(posedge pclk) disable iff (!presetn)
    stat_irq_q |=> id_q == IRQ_STAT;
  endproperty
  a_stat_top: assert property (p_stat_top) else $error("status not on top");

  property p_first_obj;
    @(posedge pclk) disable iff (!presetn)
    !stat_irq_q && pend_vec[0] |=> id_q == 16'h0001;
  endproperty
  a_first_obj: assert property (p_first_obj) else $error("object 1 not chosen");

  property p_id_zero;
    @(posedge pclk) disable iff (!presetn)
    !stat_irq_q && pend_vec == '0 |=> id_q == IRQ_NONE;
  endproperty
  a_id_zero: assert property (p_id_zero) else $error("identifier not zero");

  sequence s_cpu_stat_wr;
    wr_take && (idx == IDX_STAT) && !core_ev.stat_valid;
  endsequence

  property p_cpu_stat;
    @(posedge pclk) disable iff (!presetn)
    s_cpu_stat_wr |=> stat_irq_q == $past(stat_irq_q);
  endproperty
  a_cpu_stat: assert property (p_cpu_stat) else $error("cpu write moved status irq");

  property p_line;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> controller_irq_line == (($past(id_q) != IRQ_NONE && $past(ie_q)) == $past(pol_q));
  endproperty
  a_line: assert property (p_line) else $error("interrupt line level wrong");
endmodule

`default_nettype wire

// [testbench/can_core_model.sv]
// Purpose: behavioural protocol core feeding frame and status events
// Assumes: every event is a one-cycle pulse launched after a rising edge
// Notes:   payload is inverted once released so stale data never looks valid

`timescale 1ns/1ps
`default_nettype none

module can_core_model (
  input  wire logic                  pclk,
  output var  can_irq_pkg::core_ev_s ev
);
  import can_irq_pkg::*;

  initial ev = '0;

  // ----------------------------------------
  // frame and status events
  // ----------------------------------------
  task automatic rx(input logic [5:0] obj, input logic rem, input logic ex,
                    input logic mk, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge pclk);
    ev.rx_valid      <= 1'b1;
    ev.rx_remote     <= rem;
    ev.rx_hit_exact  <= ex;
    ev.rx_hit_masked <= mk;
    ev.rx_obj        <= obj;
    ev.rx_dlc        <= dlc;
    ev.rx_data       <= d;
    @(posedge pclk);
    ev.rx_valid      <= 1'b0;
    ev.rx_dlc        <= ~dlc;
    ev.rx_data       <= ~d;
  endtask

  task automatic tx(input logic [5:0] obj);
    @(posedge pclk);
    ev.tx_done <= 1'b1;
    ev.tx_obj  <= obj;
    @(posedge pclk);
    ev.tx_done <= 1'b0;
    ev.tx_obj  <= ~obj;
  endtask

  task automatic stat(input logic [4:0] v);
    @(posedge pclk);
    ev.stat_valid <= 1'b1;
    ev.stat_val   <= v;
    @(posedge pclk);
    ev.stat_valid <= 1'b0;
    ev.stat_val   <= ~v;
  endtask
endmodule

`default_nettype wire

// [testbench/tb_can_msg_irq.sv]
// Purpose: register-level test of flags, data buffer and interrupt identifier
// Assumes: bus answer awaited at rising edges, event effects settle within four edges
// Notes:   object flags reach the objects only through the command register

`timescale 1ns/1ps
`default_nettype none

module tb_can_msg_irq;
  import can_irq_pkg::*;
  localparam logic [63:0] D1 = 64'h0123456789ABCDEF;
  localparam logic [63:0] D2 = 64'hF0E1D2C3B4A59687;
  logic        pclk    = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  core_ev_s    core_ev;
  logic [31:0] obj_send_request;
  logic        controller_irq_line;
  logic [31:0] rv;
  logic        err;
  int          bad_count  = 0;
  int          n_compared = 0;

  always #2 pclk = ~pclk;

  can_core_model can_core_model_inst (.pclk(pclk), .ev(core_ev));

  can_msg_irq can_msg_irq_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_ev(core_ev),
    .obj_send_request(obj_send_request), .controller_irq_line(controller_irq_line)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge; answer taken there
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv  = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: no bus answer", $time);
      wrap_up();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, {2'b00, idx, 2'b00}, {24'h0, d});
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
    xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0);
    check(rv, e);
  endtask

  task automatic set_obj(input logic [5:0] obj, input logic [7:0] ctl, input logic [7:0] cfg);
    wr(IDX_CTRL, ctl);
    wr(IDX_CFG, cfg);
    wr(IDX_CMD, {2'b10, obj});
  endtask

  task automatic settle;
    repeat (4) @(posedge pclk);
  endtask

  task automatic line_chk(input logic e);
    check({31'h0, controller_irq_line}, {31'h0, e});
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    presetn <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 12'h000;
    pwdata  <= 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(IDX_ID_LO, 32'h0);
    rd_chk(IDX_ID_HI, 32'h0);
    for (int k = 0; k < 8; k++) rd_chk(IDX_DATA0 + 8'(k), 32'h0);
    wr(IDX_ID_LO, 8'h55);
    rd_chk(IDX_ID_LO, 32'h0);
    xfer(1'b0, 12'h0C0, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rv, 32'h0);
    xfer(1'b0, 12'h022, 32'h0);
    check({31'h0, err}, 32'h1);
    xfer(1'b0, 12'h420, 32'h0);
    check({31'h0, err}, 32'h1);
    line_chk(1'b0);
    check(obj_send_request, 32'h0);
    $display("test reset done");

    set_obj(6'd3, 8'h04, 8'h80);
    can_core_model_inst.rx(6'd3, 1'b0, 1'b1, 1'b0, 4'h4, D1);
    settle();
    rd_chk(IDX_ID_LO, 32'h3);
    line_chk(1'b0);
    wr(IDX_CANCTL, 8'h02);
    settle();
    line_chk(1'b1);
    can_core_model_inst.rx(6'd3, 1'b0, 1'b1, 1'b0, 4'hC, D2);
    settle();
    wr(IDX_CMD, 8'h43);
    rd_chk(IDX_CTRL, 32'hE4);
    rd_chk(IDX_CFG, 32'h8C);
    for (int k = 0; k < 8; k++) rd_chk(IDX_DATA0 + 8'(k), {24'h0, D2[8*k +: 8]});
    rd_chk(IDX_ID_LO, 32'h0);
    settle();
    line_chk(1'b0);
    $display("test receive done");

    set_obj(6'd2, 8'h04, 8'h80);
    set_obj(6'd4, 8'h14, 8'h80);
    set_obj(6'd6, 8'h04, 8'h80);
    can_core_model_inst.rx(6'd6, 1'b0, 1'b0, 1'b1, 4'h8, D1);
    can_core_model_inst.rx(6'd4, 1'b0, 1'b0, 1'b1, 4'h8, D1);
    can_core_model_inst.rx(6'd2, 1'b0, 1'b1, 1'b0, 4'h8, D1);
    can_core_model_inst.stat(5'h08);
    settle();
    rd_chk(IDX_ID_HI, 32'h80);
    rd_chk(IDX_ID_LO, 32'h00);
    rd_chk(IDX_ID_HI, 32'h80);
    wr(IDX_STAT, 8'h00);
    rd_chk(IDX_ID_HI, 32'h80);
    rd_chk(IDX_STAT, 32'h0);
    settle();
    rd_chk(IDX_ID_LO, 32'h2);
    can_core_model_inst.stat(5'h00);
    settle();
    rd_chk(IDX_ID_HI, 32'h80);
    rd_chk(IDX_STAT, 32'h0);
    wr(IDX_STAT, 8'h1F);
    settle();
    rd_chk(IDX_ID_LO, 32'h2);
    wr(IDX_CMD, 8'h42);
    settle();
    rd_chk(IDX_ID_LO, 32'h4);
    wr(IDX_CMD, 8'h44);
    settle();
    rd_chk(IDX_ID_LO, 32'h0);
    $display("test priority done");

    wr(IDX_FUNC, 8'h00);
    settle();
    line_chk(1'b1);
    wr(IDX_CANCTL, 8'h00);
    can_core_model_inst.rx(6'd2, 1'b0, 1'b1, 1'b0, 4'h8, D1);
    can_core_model_inst.stat(5'h01);
    settle();
    rd_chk(IDX_ID_LO, 32'h2);
    rd_chk(IDX_ID_HI, 32'h0);
    line_chk(1'b1);
    wr(IDX_CANCTL, 8'h02);
    settle();
    line_chk(1'b0);
    wr(IDX_CMD, 8'h42);
    settle();
    line_chk(1'b1);
    wr(IDX_FUNC, 8'h01);
    $display("test polarity done");

    set_obj(6'd7, 8'h0A, 8'hA0);
    set_obj(6'd8, 8'h00, 8'hA0);
    can_core_model_inst.rx(6'd7, 1'b1, 1'b1, 1'b0, 4'h0, D1);
    can_core_model_inst.rx(6'd8, 1'b1, 1'b1, 1'b0, 4'h0, D1);
    settle();
    check(obj_send_request, 32'h40);
    can_core_model_inst.tx(6'd7);
    can_core_model_inst.tx(6'd8);
    settle();
    check(obj_send_request, 32'h0);
    rd_chk(IDX_ID_LO, 32'h7);
    wr(IDX_CMD, 8'h47);
    settle();
    rd_chk(IDX_ID_LO, 32'h0);
    set_obj(6'd8, 8'h01, 8'hA0);
    settle();
    check(obj_send_request, 32'h80);
    can_core_model_inst.tx(6'd8);
    settle();
    check(obj_send_request, 32'h0);
    set_obj(6'd1, 8'h22, 8'h80);
    can_core_model_inst.rx(6'd1, 1'b1, 1'b1, 1'b0, 4'h0, D1);
    settle();
    check(obj_send_request, 32'h0);
    rd_chk(IDX_ID_LO, 32'h1);
    wr(IDX_CMD, 8'h41);
    settle();
    rd_chk(IDX_ID_LO, 32'h0);
    $display("test transmit done");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule

`default_nettype wire
